/* serial_port_map.svh */
`ifndef SERIAL_PORT_MAP_SVH
`define SERIAL_PORT_MAP_SVH
// register indices (word addresses are four times these)
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_RADIO_TX 4'h2
`define REG_RADIO_RX 4'h3
`define REG_COUNTS 4'h4
// control field positions
`define CTRL_SW_FLOW 0
`define CTRL_HOLD_LO 1
`define CTRL_HOLD_HI 2
`define CTRL_BAUD 3
`define CTRL_RADIO_BUSY 4
`define CTRL_GAP_LO 8
`define CTRL_GAP_HI 15
`define CTRL_FT_LO 16
`define CTRL_FT_HI 23
`define CTRL_RESET 32'h0011_0300
// flow control figures
`define FLOW_OFF_MARGIN 8'h11
`define FLOW_ON_FREE 8'h22
`define HOLD_RTS 2'h2
`define XON_CHAR 8'h11
`define XOFF_CHAR 8'h13
// timing figures in microseconds, clock rate, byte limit and bit divisors in clocks
`define CLK_MHZ 100
`define CHAN_INIT_US 35000
`define RX_IND_BASE_19K_US 790
`define RX_IND_BYTE_19K_US 408
`define RX_IND_MAX_19K_US 26900
`define RX_IND_MAX_9K6_US 30200
`define RX_IND_BYTES_19K 64
`define LAT_BASE_US 41600
`define LAT_BYTE_US 400
`define LAT_MAX_19K_US 66800
`define LAT_MAX_9K6_US 74800
`define BIT_DIV_19K 16'd5208
`define BIT_DIV_9K6 16'd10417
`endif

/* serial_port_pkg.sv */
package serial_port_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} uart_state_type;
  typedef enum logic [1:0] {RF_IDLE, RF_GAP, RF_INIT, RF_SEND} radio_state_type;
endpackage

/* byte_fifo.sv */
`timescale 1ns/100ps
module byte_fifo import serial_port_pkg::*; #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic i_mclk, // clock
  input wire logic i_nrst, // async reset, low
  input wire logic i_ce, // clock enable
  input wire logic i_wr, // push
  input wire logic [7:0] i_wdata, // push data
  input wire logic i_rd, // pop
  output logic [7:0] o_rdata, // head byte
  output logic o_empty, // no data
  output logic o_full, // no room
  output logic [AW:0] o_count // bytes held
);
  initial begin
    if (DEPTH != (1 << AW)) $error("byte_fifo depth must be two to AW");
  end
  logic [7:0] mem [DEPTH];
  logic [AW:0] wp_ff;
  logic [AW:0] rp_ff;
  logic do_wr;
  logic do_rd;
  assign do_wr = i_wr && !o_full;
  assign do_rd = i_rd && !o_empty;
  assign o_count = wp_ff - rp_ff;
  assign o_empty = (wp_ff == rp_ff);
  assign o_full = (o_count == (AW+1)'(DEPTH));
  assign o_rdata = mem[rp_ff[AW-1:0]];
  // storage write, a full buffer drops the byte
  always_ff @(posedge i_mclk) begin
    if (i_ce && do_wr) begin
      mem[wp_ff[AW-1:0]] <= i_wdata;
    end
  end
  // pointers
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else if (i_ce) begin
      if (do_wr) begin
        wp_ff <= wp_ff + 1'b1;
      end
      if (do_rd) begin
        rp_ff <= rp_ff + 1'b1;
      end
    end
  end
endmodule // byte_fifo

/* uart_tx.sv */
`timescale 1ns/100ps
module uart_tx import serial_port_pkg::*; (
  input wire logic i_mclk, // clock
  input wire logic i_nrst, // async reset, low
  input wire logic i_ce, // clock enable
  input wire logic [15:0] i_div, // clocks per bit
  input wire logic i_start, // send byte pulse
  input wire logic [7:0] i_data, // byte to send
  output logic o_busy, // frame in progress
  output logic o_line // serial output, idles high
);
  uart_state_type st_ff;
  logic [15:0] cnt_ff;
  logic [2:0] bit_ff;
  logic [7:0] sh_ff;
  logic tick;
  assign tick = (cnt_ff == 16'h0000);
  assign o_busy = (st_ff != ST_IDLE);
  // start, lsb first data, one stop bit
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_ff <= ST_IDLE;
      cnt_ff <= 16'h0000;
      bit_ff <= 3'h0;
      sh_ff <= 8'h00;
      o_line <= 1'b1;
    end else if (i_ce) begin
      cnt_ff <= tick ? i_div - 16'h0001 : cnt_ff - 16'h0001;
      case (st_ff)
        ST_IDLE: begin
          o_line <= 1'b1;
          if (i_start) begin
            sh_ff <= i_data;
            st_ff <= ST_START;
            cnt_ff <= i_div - 16'h0001;
            o_line <= 1'b0;
          end
        end
        ST_START: begin
          if (tick) begin
            o_line <= sh_ff[0];
            bit_ff <= 3'h0;
            st_ff <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (tick) begin
            if (bit_ff == 3'h7) begin
              o_line <= 1'b1;
              st_ff <= ST_STOP;
            end else begin
              o_line <= sh_ff[bit_ff+3'h1];
              bit_ff <= bit_ff + 3'h1;
            end
          end
        end
        ST_STOP: begin
          if (tick) begin
            st_ff <= ST_IDLE;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end
endmodule // uart_tx

/* serial_port.sv */
`timescale 1ns/100ps
`include "serial_port_map.svh"
//
// Operation
// - frames are start low, eight data bits lsb first, stop high.
// - every received serial byte but xon/xoff under software flow waits in the input buffer; a byte arriving at a full buffer is dropped.
// - first buffered byte starts the flow when radio not receiving.
// - radio connection opens only after the gap threshold holds.
// - during radio reception new bytes stay in the input buffer.
// - held bytes go out once radio reception ends.
// - cts goes high when buffer within threshold of full.
// - cts returns low only with thirty-four bytes free.
// - radio data goes into output buffer, then out serially.
// - full output buffer drops further radio data.
// - hold select two stops output buffer data, not xon/xoff, while rts is high.
// - software flow enable honours and issues xon and xoff.
// - first packet is preceded by 35 ms channel initialization.
// - receive indicator length follows the byte count formula at 19K baud; at 9K6 it is always the maximum.
// - end to end latency follows the documented figures.
// - receive indicator high during reception, low otherwise.
module serial_port import serial_port_pkg::*; #(
  parameter int IN_DEPTH = 256,
  parameter int IN_AW = 8,
  parameter int OUT_DEPTH = 256,
  parameter int OUT_AW = 8,
  parameter int CHAN_INIT_CYC = `CHAN_INIT_US * `CLK_MHZ,
  parameter int RX_UNIT_CYC = `CLK_MHZ
) (
  input wire logic i_mclk, // clock
  input wire logic i_nrst, // async reset, low
  input wire logic i_ce, // clock enable
  input wire logic i_host_to_module_line, // serial data from host
  input wire logic i_rts_n, // host request to send, low
  output logic o_module_to_host_line, // serial data to host
  output logic o_cts_n, // clear to send, low
  output logic o_receive_indicator, // radio reception active
  input wire logic [3:0] i_addr, // register index
  input wire logic [31:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [31:0] o_rdata, // read data, next cycle
  output logic o_radio_tx_valid, // byte offered to radio
  output logic [7:0] o_radio_tx_data, // byte to radio
  output logic o_chan_init // channel initialization running
);
  initial begin
    if (IN_DEPTH < 64 || OUT_DEPTH < 2) $error("serial_port buffer depths too small");
    if (CHAN_INIT_CYC < 1 || RX_UNIT_CYC < 1) $error("serial_port timing counts too small");
  end
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] rx_sync_ff;
  logic [1:0] rts_sync_ff;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_sync_ff <= 2'b11;
      rts_sync_ff <= 2'b11;
    end else if (i_ce) begin
      rx_sync_ff <= {rx_sync_ff[0], i_host_to_module_line};
      rts_sync_ff <= {rts_sync_ff[0], i_rts_n};
    end
  end
  logic rx_line;
  logic rts_high;
  assign rx_line = rx_sync_ff[1];
  assign rts_high = rts_sync_ff[1];
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] ctrl_ff;
  logic sw_flow;
  logic [1:0] host_hold_select;
  logic [7:0] packet_gap_threshold;
  logic [7:0] flow_threshold_setting;
  logic radio_busy;
  logic [15:0] bit_div;
  assign sw_flow = ctrl_ff[`CTRL_SW_FLOW];
  assign host_hold_select = ctrl_ff[`CTRL_HOLD_HI:`CTRL_HOLD_LO];
  assign packet_gap_threshold = ctrl_ff[`CTRL_GAP_HI:`CTRL_GAP_LO];
  assign flow_threshold_setting = ctrl_ff[`CTRL_FT_HI:`CTRL_FT_LO];
  assign radio_busy = ctrl_ff[`CTRL_RADIO_BUSY];
  assign bit_div = ctrl_ff[`CTRL_BAUD] ? `BIT_DIV_9K6 : `BIT_DIV_19K;
  logic rf_push;
  assign rf_push = i_ce && i_wr && (i_addr == `REG_RADIO_RX);
  // control register
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_ff <= `CTRL_RESET;
    end else if (i_ce && i_wr && i_addr == `REG_CTRL) begin
      ctrl_ff <= i_wdata;
    end
  end
  // ----------------------------------------
  // serial receiver
  // ----------------------------------------
  uart_state_type rx_st_ff;
  logic [15:0] rx_cnt_ff;
  logic [2:0] rx_bit_ff;
  logic [7:0] rx_sh_ff;
  logic rx_done_ff;
  logic [15:0] idle_bits_ff;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_st_ff <= ST_IDLE;
      rx_cnt_ff <= 16'h0000;
      rx_bit_ff <= 3'h0;
      rx_sh_ff <= 8'h00;
      rx_done_ff <= 1'b0;
    end else if (i_ce) begin
      rx_done_ff <= 1'b0;
      rx_cnt_ff <= rx_cnt_ff - 16'h0001;
      case (rx_st_ff)
        ST_IDLE: begin
          if (!rx_line) begin
            rx_st_ff <= ST_START;
            rx_cnt_ff <= {1'b0, bit_div[15:1]};
          end
        end
        ST_START: begin
          if (rx_cnt_ff == 16'h0000) begin
            rx_st_ff <= rx_line ? ST_IDLE : ST_DATA;
            rx_cnt_ff <= bit_div - 16'h0001;
            rx_bit_ff <= 3'h0;
          end
        end
        ST_DATA: begin
          if (rx_cnt_ff == 16'h0000) begin
            rx_sh_ff <= {rx_line, rx_sh_ff[7:1]};
            rx_cnt_ff <= bit_div - 16'h0001;
            rx_bit_ff <= rx_bit_ff + 3'h1;
            if (rx_bit_ff == 3'h7) begin
              rx_st_ff <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (rx_cnt_ff == 16'h0000) begin
            rx_st_ff <= ST_IDLE;
            rx_done_ff <= rx_line;
          end
        end
        default: rx_st_ff <= ST_IDLE;
      endcase
    end
  end
  // idle gap length in bit times since the last byte
  logic [15:0] gap_cnt_ff;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      idle_bits_ff <= 16'h0000;
      gap_cnt_ff <= 16'h0000;
    end else if (i_ce) begin
      if (rx_st_ff != ST_IDLE) begin
        idle_bits_ff <= 16'h0000;
        gap_cnt_ff <= 16'h0000;
      end else if (gap_cnt_ff >= bit_div - 16'h0001) begin
        gap_cnt_ff <= 16'h0000;
        if (idle_bits_ff != 16'hffff) begin
          idle_bits_ff <= idle_bits_ff + 16'h0001;
        end
      end else begin
        gap_cnt_ff <= gap_cnt_ff + 16'h0001;
      end
    end
  end
  // software flow: incoming xoff pauses output, incoming xon resumes it
  logic xoff_seen_ff;
  logic is_flow_char;
  assign is_flow_char = sw_flow && (rx_sh_ff == `XON_CHAR || rx_sh_ff == `XOFF_CHAR);
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      xoff_seen_ff <= 1'b0;
    end else if (i_ce) begin
      if (!sw_flow) begin
        xoff_seen_ff <= 1'b0;
      end else if (rx_done_ff && rx_sh_ff == `XOFF_CHAR) begin
        xoff_seen_ff <= 1'b1;
      end else if (rx_done_ff && rx_sh_ff == `XON_CHAR) begin
        xoff_seen_ff <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // input buffer and radio side
  // ----------------------------------------
  logic [7:0] in_head;
  logic in_empty;
  logic in_full;
  logic [IN_AW:0] in_count;
  logic in_pop;
  byte_fifo #(.DEPTH(IN_DEPTH), .AW(IN_AW)) u_input_buffer (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_wr(rx_done_ff && !is_flow_char),
    .i_wdata(rx_sh_ff),
    .i_rd(in_pop),
    .o_rdata(in_head),
    .o_empty(in_empty),
    .o_full(in_full),
    .o_count(in_count)
  );
  radio_state_type rf_st_ff;
  logic [31:0] init_cnt_ff;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rf_st_ff <= RF_IDLE;
      init_cnt_ff <= 32'h0000_0000;
      o_chan_init <= 1'b0;
    end else if (i_ce) begin
      case (rf_st_ff)
        RF_IDLE: begin
          if (!in_empty) begin
            rf_st_ff <= RF_GAP;
          end
        end
        RF_GAP: begin
          if (!radio_busy && idle_bits_ff >= {8'h00, packet_gap_threshold}) begin
            rf_st_ff <= RF_INIT;
            init_cnt_ff <= 32'(CHAN_INIT_CYC - 1);
            o_chan_init <= 1'b1;
          end
        end
        RF_INIT: begin
          if (init_cnt_ff == 32'h0000_0000) begin
            rf_st_ff <= RF_SEND;
            o_chan_init <= 1'b0;
          end else begin
            init_cnt_ff <= init_cnt_ff - 32'h0000_0001;
          end
        end
        RF_SEND: begin
          if (in_empty) begin
            rf_st_ff <= RF_IDLE;
          end
        end
        default: rf_st_ff <= RF_IDLE;
      endcase
    end
  end
  assign in_pop = (rf_st_ff == RF_SEND) && !radio_busy && !o_radio_tx_valid;
  // one byte per pop offered to the radio
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_radio_tx_valid <= 1'b0;
      o_radio_tx_data <= 8'h00;
    end else if (i_ce) begin
      o_radio_tx_valid <= in_pop && !in_empty;
      // keep the last byte, the head of an empty buffer is stale
      if (in_pop && !in_empty) begin
        o_radio_tx_data <= in_head;
      end
    end
  end
  // ----------------------------------------
  // hardware flow control on input buffer
  // ----------------------------------------
  logic [IN_AW:0] in_free;
  assign in_free = (IN_AW+1)'(IN_DEPTH) - in_count;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cts_n <= 1'b0;
    end else if (i_ce) begin
      if (in_free <= (IN_AW+1)'(flow_threshold_setting)) begin
        o_cts_n <= 1'b1;
      end else if (in_free >= (IN_AW+1)'(`FLOW_ON_FREE)) begin
        o_cts_n <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // output buffer and serial transmitter
  // ----------------------------------------
  logic [7:0] out_head;
  logic out_empty;
  logic out_full;
  logic out_pop;
  logic tx_busy;
  logic tx_start;
  logic [7:0] tx_byte;
  logic xoff_sent_ff;
  logic want_xoff;
  logic want_xon;
  logic out_hold;
  byte_fifo #(.DEPTH(OUT_DEPTH), .AW(OUT_AW)) u_output_buffer (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_wr(i_wr && i_addr == `REG_RADIO_RX),
    .i_wdata(i_wdata[7:0]),
    .i_rd(out_pop),
    .o_rdata(out_head),
    .o_empty(out_empty),
    .o_full(out_full),
    .o_count()
  );
  // issue xoff/xon as input room changes
  assign want_xoff = sw_flow && o_cts_n && !xoff_sent_ff;
  assign want_xon = sw_flow && !o_cts_n && xoff_sent_ff;
  assign out_hold = (host_hold_select == `HOLD_RTS && rts_high) || xoff_seen_ff;
  assign tx_start = !tx_busy && (want_xoff || want_xon || (!out_empty && !out_hold));
  assign tx_byte = want_xoff ? `XOFF_CHAR : (want_xon ? `XON_CHAR : out_head);
  assign out_pop = tx_start && !want_xoff && !want_xon;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      xoff_sent_ff <= 1'b0;
    end else if (i_ce && tx_start) begin
      xoff_sent_ff <= want_xoff ? 1'b1 : (want_xon ? 1'b0 : xoff_sent_ff);
    end
  end
  uart_tx u_tx (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_div(bit_div),
    .i_start(tx_start),
    .i_data(tx_byte),
    .o_busy(tx_busy),
    .o_line(o_module_to_host_line)
  );
  // ----------------------------------------
  // receive indicator timing
  // ----------------------------------------
  logic [7:0] rx_bytes_ff;
  logic [31:0] ind_us;
  logic [31:0] ind_cnt_ff;
  logic [31:0] lat_us;
  logic [8:0] burst_bytes;
  // burst count including the byte written now
  assign burst_bytes = {1'b0, rx_bytes_ff} + 9'h001;
  always_comb begin
    ind_us = `RX_IND_BASE_19K_US + `RX_IND_BYTE_19K_US * 32'(burst_bytes);
    if (burst_bytes > 9'(`RX_IND_BYTES_19K)) begin
      ind_us = `RX_IND_MAX_19K_US;
    end
    if (ctrl_ff[`CTRL_BAUD]) begin
      ind_us = `RX_IND_MAX_9K6_US;
    end
  end
  // latency estimate reported for the burst
  always_comb begin
    lat_us = `LAT_BASE_US + `LAT_BYTE_US * 32'(rx_bytes_ff);
    if (rx_bytes_ff > 8'(`RX_IND_BYTES_19K - 1)) begin
      lat_us = `LAT_MAX_19K_US;
    end
    if (ctrl_ff[`CTRL_BAUD]) begin
      lat_us = `LAT_MAX_9K6_US;
    end
  end
  // burst byte count, cleared when reception ends
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_bytes_ff <= 8'h00;
    end else if (i_ce) begin
      if (rf_push && rx_bytes_ff != 8'hff) begin
        rx_bytes_ff <= rx_bytes_ff + 8'h01;
      end else if (!radio_busy && ind_cnt_ff == 32'h0000_0000) begin
        rx_bytes_ff <= 8'h00;
      end
    end
  end
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ind_cnt_ff <= 32'h0000_0000;
      o_receive_indicator <= 1'b0;
    end else if (i_ce) begin
      if (rf_push) begin
        ind_cnt_ff <= 32'(ind_us * 32'(RX_UNIT_CYC));
      end else if (ind_cnt_ff != 32'h0000_0000) begin
        ind_cnt_ff <= ind_cnt_ff - 32'h0000_0001;
      end
      o_receive_indicator <= radio_busy || (ind_cnt_ff != 32'h0000_0000);
    end
  end
  // ----------------------------------------
  // register read
  // ----------------------------------------
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_ce) begin
      o_rdata <= 32'h0000_0000;
      if (i_rd) begin
        case (i_addr)
          `REG_CTRL: o_rdata <= ctrl_ff;
          `REG_STATUS: o_rdata <= {24'h00_0000, in_empty, in_full, out_empty, out_full,
                                   xoff_seen_ff, o_cts_n, o_receive_indicator, o_chan_init};
          `REG_RADIO_TX: o_rdata <= {24'h00_0000, o_radio_tx_data};
          `REG_COUNTS: o_rdata <= {8'h00, 8'(in_count), lat_us[15:0]};
          default: o_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // serial_port

/* serial_port_assertions.sv */
`timescale 1ns/100ps
module serial_port_checker #(
  parameter int CHAN_INIT_CYC = 20
) (
  input wire logic i_mclk, // clock
  input wire logic i_nrst, // reset, low
  input wire logic i_rts_n, // host hold
  input wire logic [3:0] i_addr, // index
  input wire logic [31:0] i_wdata, // wr data
  input wire logic i_wr, // wr strobe
  input wire logic i_rd, // rd strobe
  input wire logic [31:0] o_rdata, // rd data
  input wire logic o_module_to_host_line, // serial out
  input wire logic o_receive_indicator, // rx ind
  input wire logic o_radio_tx_valid, // radio byte
  input wire logic o_chan_init // chan init
);
  logic busy_ff;
  logic hold_ff;
  int init_ff;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // shadow of busy and hold select fields
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_ff <= 1'b0;
      hold_ff <= 1'b0;
    end else if (i_wr && i_addr == 4'h0) begin
      busy_ff <= i_wdata[4];
      hold_ff <= i_wdata[2:1] == 2'h2;
    end
  end
  // length of the current init run
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) init_ff <= 0;
    else init_ff <= o_chan_init ? init_ff + 1 : 0;
  end
  sequence s_rts_held;
    (hold_ff && i_rts_n) [*4];
  endsequence
  sequence s_busy_idle;
    (busy_ff && !o_chan_init) [*4] ##1 busy_ff;
  endsequence
  a_init_length: assert property ($fell(o_chan_init) |-> init_ff == CHAN_INIT_CYC)
    else $error("channel init length wrong");
  a_valid_pulse: assert property (o_radio_tx_valid |=> !o_radio_tx_valid)
    else $error("radio valid longer than one cycle");
  a_valid_after_init: assert property (o_radio_tx_valid |-> !o_chan_init)
    else $error("radio byte during channel init");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
    else $error("read data outside read answer");
  a_hold_rts: assert property (s_rts_held |=> !$fell(o_module_to_host_line))
    else $error("frame started while host holds off");
  a_rx_ind: assert property ($rose(busy_ff) |-> ##[1:4] o_receive_indicator)
    else $error("receive indicator not raised");
  a_busy_hold: assert property (s_busy_idle |-> !o_chan_init)
    else $error("transmission started during reception");
  a_start_bit: assert property ($fell(o_module_to_host_line) |-> !o_module_to_host_line [*8])
    else $error("start bit too short");
endmodule // serial_port_checker

bind serial_port serial_port_checker #(.CHAN_INIT_CYC(CHAN_INIT_CYC)) u_chk (
  .i_mclk(i_mclk), .i_nrst(i_nrst), .i_rts_n(i_rts_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_module_to_host_line(o_module_to_host_line), .o_receive_indicator(o_receive_indicator),
  .o_radio_tx_valid(o_radio_tx_valid), .o_chan_init(o_chan_init));

/* host_uart.sv */
`timescale 1ns/100ps
`include "serial_port_map.svh"
module host_uart (
  input wire logic i_mclk, // clock
  input wire logic i_cts_n, // module ready
  input wire logic i_line, // from module
  output logic o_line // to module
);
  localparam int DIV = `BIT_DIV_19K;
  logic [9:0] frame;
  initial o_line = 1'b1;
  task automatic send(input logic [7:0] b, output logic ok);
    int n;
    for (n = 0; n < 1000 && i_cts_n !== 1'b0; n++) @(posedge i_mclk);
    ok = i_cts_n === 1'b0;
    frame = {1'b1, b, 1'b0};
    for (n = 0; ok && n < 10; n++) begin
      o_line <= frame[n];
      repeat (DIV) @(posedge i_mclk);
    end
  endtask
  // sample each bit in its middle
  task automatic recv(output logic [7:0] b, output logic ok);
    int n;
    b = 8'h00;
    for (n = 0; n < 2000 && i_line !== 1'b0; n++) @(posedge i_mclk);
    repeat (DIV / 2) @(posedge i_mclk);
    ok = i_line === 1'b0;
    for (n = 0; n < 8; n++) begin
      repeat (DIV) @(posedge i_mclk);
      b[n] = i_line;
    end
    repeat (DIV) @(posedge i_mclk);
    ok = ok && i_line === 1'b1;
  endtask
endmodule // host_uart

/* testbench.sv */
`timescale 1ns/100ps
`include "serial_port_map.svh"
module testbench;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_rts_n = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic host_line;
  logic o_module_to_host_line, o_cts_n, o_receive_indicator, o_radio_tx_valid, o_chan_init;
  logic [31:0] o_rdata;
  logic [31:0] d;
  logic [7:0] o_radio_tx_data;
  logic [7:0] tx_byte = 8'h00;
  logic [7:0] got;
  logic ok;
  logic watch = 1'b0;
  int num_errors = 0;
  int n_compared = 0;
  int tx_cnt = 0;
  int init_cnt = 0;
  int line_low = 0;
  int n;
  logic [3:0] row_addr [6] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'hf, 4'h4};
  logic [31:0] row_exp [6] = '{`CTRL_RESET, 32'h0000_00a0, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_a280};

  serial_port #(.OUT_DEPTH(4), .OUT_AW(2), .CHAN_INIT_CYC(20), .RX_UNIT_CYC(1)) dut (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(1'b1), .i_host_to_module_line(host_line),
    .i_rts_n(i_rts_n), .o_module_to_host_line(o_module_to_host_line), .o_cts_n(o_cts_n),
    .o_receive_indicator(o_receive_indicator), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_radio_tx_valid(o_radio_tx_valid),
    .o_radio_tx_data(o_radio_tx_data), .o_chan_init(o_chan_init));
  host_uart host (.i_mclk(i_mclk), .i_cts_n(o_cts_n), .i_line(o_module_to_host_line),
    .o_line(host_line));

  always #5 i_mclk = ~i_mclk;
  // count radio bytes, init cycles, held line lows
  always @(posedge i_mclk) begin
    if (o_radio_tx_valid === 1'b1) begin
      tx_cnt++;
      tx_byte = o_radio_tx_data;
    end
    if (o_chan_init === 1'b1) init_cnt++;
    if (watch && o_module_to_host_line !== 1'b1) line_low++;
  end

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("wrong value %s: expected %h seen %h", name, exp, seen);
      num_errors++;
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] v);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    @(posedge i_mclk);
  endtask
  task rd(input logic [3:0] a);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
    @(posedge i_mclk);
  endtask
  task reset();
    i_nrst <= 1'b0;
    repeat (25) @(posedge i_mclk);
    i_nrst <= 1'b1;
    @(posedge i_mclk);
  endtask
  task results();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    reset();
    // reset values and unmapped reads
    for (int r = 0; r < 6; r++) begin
      rd(row_addr[r]);
      chk("register", d, row_exp[r]);
    end
    wr(4'h5, 32'hffff_ffff);
    rd(4'h5);
    chk("unmapped", d, 32'h0000_0000);
    // output buffer fills while host holds off
    watch <= 1'b1;
    wr(4'h0, 32'h0011_0304);
    for (int k = 0; k < 5; k++) wr(4'h3, 32'h0000_0040 + k);
    rd(4'h1);
    chk("out full", d[5:4], 2'h1);
    reset();
    // host byte held during reception, radio byte held by rts
    wr(4'h0, 32'h0011_0314);
    wr(4'h3, 32'h0000_003c);
    host.send(8'ha5, ok);
    chk("send", ok, 1'b1);
    chk("line", line_low, 0);
    watch <= 1'b0;
    i_rts_n <= 1'b0;
    // host drains the radio byte while the held byte waits
    fork
      host.recv(got, ok);
      begin
        repeat (`BIT_DIV_19K * 4) @(posedge i_mclk);
        rd(4'h1);
        chk("held", d[7], 1'b0);
        chk("rx ind", o_receive_indicator, 1'b1);
        chk("no tx", tx_cnt + init_cnt, 0);
        rd(4'h4);
        chk("counts", d, 32'h0001_a410);
        wr(4'h0, 32'h0011_0304);
        for (n = 0; n < 20000 && tx_cnt == 0; n++) @(posedge i_mclk);
      end
    join
    chk("to host", {ok, got}, {1'b1, 8'h3c});
    chk("tx data", tx_byte, 8'ha5);
    chk("tx count", tx_cnt, 1);
    chk("init", init_cnt, 20);
    rd(4'h2);
    chk("radio tx", d[7:0], 8'ha5);
    results();
  end
endmodule // testbench
